// File: mwcc_checker.sv
/*
 Port assertions for the wake and checksum register bank.
 Assumes one clock domain and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module mwcc_checker
   import mwcc_pkg::*;
(
   // Clock and reset
   input wire logic                    clk,
   input wire logic                    rst,
   // Register port and events
   input wire mwcc_req_t               req,
   input wire logic [DATA_W-1:0]       rdata,
   input wire mwcc_rx_evt_t            rx_evt,
   // Controls and interrupt
   input wire logic                    magic_detect_on,
   input wire logic                    frame_detect_on,
   input wire logic                    wake_request,
   input wire mwcc_csum_cfg_t          csum_cfg,
   input wire logic [DATA_W-1:0]       pattern_word,
   input wire logic [FILTER_PTR_W-1:0] pattern_ptr,
   input wire logic                    irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire wk_wr = req.wr && req.addr == IDX_WAKE;
   wire cs_wr = req.wr && req.addr == IDX_CSUM;

   AST_RD_IDLE: assert property (!req.rd |=> rdata == '0)
      else $error("read data not zero outside a read");
   AST_CSUM_RD: assert property (
      req.rd && req.addr == IDX_CSUM |=> rdata ==
      {15'h0, csum_cfg.tx_engine_on, 14'h0, csum_cfg.rx_l3_start,
      csum_cfg.rx_engine_on})
      else $error("checksum read differs from outputs");
   AST_WAKE_RD: assert property (
      req.rd && req.addr == IDX_WAKE |=>
      rdata[31:10] == 22'h0 && rdata[2:1] == {frame_detect_on,
      magic_detect_on})
      else $error("wake read differs from outputs");
   AST_MAGIC_ON: assert property (wk_wr |=>
      magic_detect_on == $past(req.wdata[WK_MAGIC_EN]))
      else $error("magic detect not following write");
   AST_FRAME_ON: assert property (wk_wr |=>
      frame_detect_on == $past(req.wdata[WK_FRAME_EN]))
      else $error("frame detect not following write");
   AST_CSUM_WR: assert property (cs_wr |=>
      csum_cfg.tx_engine_on == $past(req.wdata[CS_TX_EN]) &&
      csum_cfg.rx_engine_on == $past(req.wdata[CS_RX_EN]))
      else $error("engine enables not following write");
   AST_PTR_RST: assert property (wk_wr && req.wdata[WK_PTR_RST] |=>
      pattern_ptr == '0)
      else $error("pointer reset did not rewind");
   AST_PTR_STEP: assert property (
      req.rd && req.addr == IDX_FILTER |=>
      pattern_ptr == $past(pattern_ptr) + 3'h1)
      else $error("filter read did not step pointer");
   AST_MAGIC_WAKE: assert property (
      rx_evt.valid && rx_evt.magic_match && magic_detect_on |=> wake_request)
      else $error("enabled magic packet gave no wake");
   AST_WAKE_CAUSE: assert property (wake_request |->
      $past(rx_evt.valid))
      else $error("wake request without an event");

   cover property (wake_request);
   cover property (irq);
   cover property (req.rd && req.addr == IDX_FILTER);
endmodule

bind mwcc_regs mwcc_checker mwcc_checker_inst (.clk(clk), .rst(rst),
   .req(req), .rdata(rdata), .rx_evt(rx_evt), .irq(irq),
   .magic_detect_on(magic_detect_on), .frame_detect_on(frame_detect_on),
   .wake_request(wake_request), .csum_cfg(csum_cfg),
   .pattern_word(pattern_word), .pattern_ptr(pattern_ptr));

// File: mwcc_pkg.sv
/*
 Package for the wake-up and checksum offload control register bank.
 Holds register indices, field positions, reset values and carrier types.
 Assumes a plain register port with 32-bit data and word addressing.
*/
package mwcc_pkg;
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 32;
   localparam logic [3:0]  IDX_FILTER      = 4'hB;
   localparam logic [3:0]  IDX_WAKE        = 4'hC;
   localparam logic [3:0]  IDX_CSUM        = 4'hD;
   localparam logic [3:0]  IDX_IRQ_STATUS  = 4'hE;
   localparam logic [3:0]  IDX_IRQ_MASK    = 4'hF;
   localparam int          WK_PTR_RST      = 31;
   localparam int          WK_GUE          = 9;
   localparam int          WK_FRAME_RX     = 6;
   localparam int          WK_MAGIC_RX     = 5;
   localparam int          WK_FRAME_EN     = 2;
   localparam int          WK_MAGIC_EN     = 1;
   localparam int          CS_TX_EN        = 16;
   localparam int          CS_RX_MODE      = 1;
   localparam int          CS_RX_EN        = 0;
   localparam int          IRQ_FRAME       = 0;
   localparam int          IRQ_MAGIC       = 1;
   localparam int          IRQ_UNICAST     = 2;
   localparam int          IRQ_W           = 3;
   localparam int          FILTER_DEPTH    = 8;
   localparam int          FILTER_PTR_W    = 3;
   localparam logic [7:0]  RX_FIXED_START  = 8'h0E;
   localparam logic [31:0] WAKE_RESET      = 32'h00000000;
   localparam logic [31:0] CSUM_RESET      = 32'h00000000;
   localparam logic [31:0] READ_UNMAPPED   = 32'h00000000;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } mwcc_req_t;

   typedef struct packed {
      logic frame_match;
      logic magic_match;
      logic valid;
      logic dst_bit0;
   } mwcc_rx_evt_t;

   typedef struct packed {
      logic       tx_engine_on;
      logic       rx_engine_on;
      logic       rx_l3_start;
      logic [7:0] rx_fixed_start;
   } mwcc_csum_cfg_t;
endpackage

// File: mwcc_regs.sv
/*
 Wake-up control/status and checksum offload control register bank.
 Also holds the eight-entry wake pattern store reached through one
 location, and an event interrupt with sticky status and mask.
 Assumes receive events come from logic on the same clock, one-cycle
 pulses qualified by valid.
*/
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module mwcc_regs
   import mwcc_pkg::*;
#(
   parameter int DEPTH = FILTER_DEPTH
)
(
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst,
   // Register port
   input  wire mwcc_req_t      req,
   output logic [DATA_W-1:0]   rdata,
   // Receive events from the MAC
   input  wire mwcc_rx_evt_t   rx_evt,
   // Controls to the wake logic and checksum engines
   output logic                magic_detect_on,
   output logic                frame_detect_on,
   output logic                wake_request,
   output mwcc_csum_cfg_t      csum_cfg,
   output logic [DATA_W-1:0]   pattern_word,
   output logic [FILTER_PTR_W-1:0] pattern_ptr,
   // Interrupt
   output logic                irq
);

   function automatic logic hit(input logic [3:0] idx);
      hit = (req.addr == idx);
   endfunction

   logic                    magic_en;
   logic                    frame_en;
   logic                    global_unicast_wake_enable;
   logic                    frame_rx;
   logic                    magic_rx;
   logic                    tx_en;
   logic                    rx_mode;
   logic                    rx_en;
   logic [IRQ_W-1:0]        irq_status;
   logic [IRQ_W-1:0]        irq_mask;
   logic [FILTER_PTR_W-1:0] wr_ptr;
   logic [FILTER_PTR_W-1:0] rd_ptr;
   logic [DATA_W-1:0]       store [DEPTH];
   logic                    wr_wake;
   logic                    ptr_rst;
   logic                    frame_evt;
   logic                    magic_evt;
   logic                    unicast_evt;
   logic [DATA_W-1:0]       next_rdata;

   assign wr_wake = req.wr && hit(IDX_WAKE);
   // The reset bit is never stored, so it reads zero afterwards.
   assign ptr_rst = wr_wake && req.wdata[WK_PTR_RST];

   assign frame_evt   = rx_evt.valid && rx_evt.frame_match
                        && frame_en;
   assign magic_evt   = rx_evt.valid && rx_evt.magic_match
                        && magic_en;
   assign unicast_evt = rx_evt.valid && !rx_evt.dst_bit0
                        && global_unicast_wake_enable;

   // Control bits.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         global_unicast_wake_enable      <= WAKE_RESET[WK_GUE];
         frame_en <= WAKE_RESET[WK_FRAME_EN];
         magic_en <= WAKE_RESET[WK_MAGIC_EN];
      end
      else if (wr_wake)
      begin
         global_unicast_wake_enable      <= req.wdata[WK_GUE];
         frame_en <= req.wdata[WK_FRAME_EN];
         magic_en <= req.wdata[WK_MAGIC_EN];
      end
   end

   // Software is trusted to change these only with the paths idle.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_en   <= CSUM_RESET[CS_TX_EN];
         rx_mode <= CSUM_RESET[CS_RX_MODE];
         rx_en   <= CSUM_RESET[CS_RX_EN];
      end
      else if (req.wr && hit(IDX_CSUM))
      begin
         tx_en   <= req.wdata[CS_TX_EN];
         rx_mode <= req.wdata[CS_RX_MODE];
         rx_en   <= req.wdata[CS_RX_EN];
      end
   end

   // Received flags latch and stay set; the register is read-only for
   // them, so only reset clears them.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         frame_rx <= WAKE_RESET[WK_FRAME_RX];
         magic_rx <= WAKE_RESET[WK_MAGIC_RX];
      end
      else
      begin
         if (frame_evt)
            frame_rx <= 1'b1;
         if (magic_evt)
            magic_rx <= 1'b1;
      end
   end

   // Sticky interrupt status; a new event wins over a write-one clear.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_status <= '0;
      else
      begin
         for (int i = 0; i < IRQ_W; i++)
         begin
            if (req.wr && hit(IDX_IRQ_STATUS) && req.wdata[i])
               irq_status[i] <= 1'b0;
         end
         if (frame_evt)
            irq_status[IRQ_FRAME] <= 1'b1;
         if (magic_evt)
            irq_status[IRQ_MAGIC] <= 1'b1;
         if (unicast_evt)
            irq_status[IRQ_UNICAST] <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_mask <= '0;
      else if (req.wr && hit(IDX_IRQ_MASK))
         irq_mask <= req.wdata[IRQ_W-1:0];
   end

   assign irq = |(irq_status & irq_mask);

   // Pattern store pointers step on each access and wrap at the end.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else if (ptr_rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (req.wr && hit(IDX_FILTER))
            wr_ptr <= (wr_ptr == FILTER_PTR_W'(DEPTH - 1)) ? '0
                      : wr_ptr + 1'b1;
         if (req.rd && hit(IDX_FILTER))
            rd_ptr <= (rd_ptr == FILTER_PTR_W'(DEPTH - 1)) ? '0
                      : rd_ptr + 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_store
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               store[g] <= '0;
            else if (req.wr && hit(IDX_FILTER)
                     && wr_ptr == FILTER_PTR_W'(g))
               store[g] <= req.wdata;
         end
      end
   endgenerate

   // Read mux; reserved and unmapped bits return zero.
   always_comb
   begin
      next_rdata = READ_UNMAPPED;
      case (req.addr)
         IDX_FILTER:
            next_rdata = store[rd_ptr];
         IDX_WAKE:
         begin
            next_rdata[WK_GUE]      = global_unicast_wake_enable;
            next_rdata[WK_FRAME_RX] = frame_rx;
            next_rdata[WK_MAGIC_RX] = magic_rx;
            next_rdata[WK_FRAME_EN] = frame_en;
            next_rdata[WK_MAGIC_EN] = magic_en;
         end
         IDX_CSUM:
         begin
            next_rdata[CS_TX_EN]   = tx_en;
            next_rdata[CS_RX_MODE] = rx_mode;
            next_rdata[CS_RX_EN]   = rx_en;
         end
         IDX_IRQ_STATUS:
            next_rdata[IRQ_W-1:0] = irq_status;
         IDX_IRQ_MASK:
            next_rdata[IRQ_W-1:0] = irq_mask;
         default:
            next_rdata = READ_UNMAPPED;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata <= '0;
      else if (req.rd)
         rdata <= next_rdata;
      else
         rdata <= '0;
   end

   // Outputs to the wake and checksum datapaths.
   assign magic_detect_on = magic_en;
   assign frame_detect_on = frame_en;
   // Leaving power-save is requested on any enabled wake event.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wake_request <= 1'b0;
      else
         wake_request <= unicast_evt || frame_evt || magic_evt;
   end

   // Software keeps the receive engine off while pad stripping runs.
   assign csum_cfg.tx_engine_on   = tx_en;
   assign csum_cfg.rx_engine_on   = rx_en;
   assign csum_cfg.rx_l3_start    = rx_mode;
   assign csum_cfg.rx_fixed_start = RX_FIXED_START;
   assign pattern_word = store[rd_ptr];
   assign pattern_ptr  = rd_ptr;

endmodule

// File: tb.sv
/*
 Self-checking bench for the wake and checksum register bank.
 Assumes the register port answers reads in the following cycle.
*/
`timescale 1ns/1ps
module tb;
   import mwcc_pkg::*;
   logic           clk = 0;
   logic           rst = 1;
   mwcc_req_t      req = '0;
   mwcc_rx_evt_t   ev = '0;
   logic [31:0]    rdata, pword;
   logic [2:0]     pptr;
   logic           mon, fon, wrq, irq;
   mwcc_csum_cfg_t cfg;
   int             err_count = 0, num_checks = 0, cyc = 0, rp = 0, wp = 0;
   logic [31:0]    wk = 0, cs = 0, st = 0, mk = 0, filt[8] = '{default: 0};
   always #10 clk = ~clk;
   mwcc_regs mwcc_regs_inst (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
      .rx_evt(ev), .magic_detect_on(mon), .frame_detect_on(fon),
      .wake_request(wrq), .csum_cfg(cfg), .pattern_word(pword),
      .pattern_ptr(pptr), .irq(irq));

   task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic outs;
      @(negedge clk);
      check("irq", irq, 32'(|(st & mk)));
      check("magic_on", mon, wk[1]);
      check("frame_on", fon, wk[2]);
      check("csum_cfg", cfg, {cs[16], cs[0], cs[1], 8'h0E});
      check("ptr", pptr, rp);
      check("word", pword, filt[rp]);
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
      if (a == IDX_WAKE) wk = wk & 32'h60 | d & 32'h206;
      if (a == IDX_WAKE && d[WK_PTR_RST]) {rp, wp} = 0;
      if (a == IDX_CSUM) cs = d & 32'h10003;
      if (a == IDX_IRQ_STATUS) st = st & ~d;
      if (a == IDX_IRQ_MASK) mk = d & 32'h7;
      if (a == IDX_FILTER) filt[wp] = d;
      if (a == IDX_FILTER) wp = (wp + 1) % 8;
   endtask
   task automatic rd(logic [3:0] a);
      logic [31:0] e;
      e = a == IDX_WAKE ? wk : a == IDX_CSUM ? cs : a == IDX_IRQ_STATUS ? st
         : a == IDX_IRQ_MASK ? mk : a == IDX_FILTER ? filt[rp] : 32'h0;
      if (a == IDX_FILTER) rp = (rp + 1) % 8;
      @(posedge clk);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      @(negedge clk);
      check("rdata", rdata, e);
   endtask
   task automatic evt(logic [3:0] e);
      logic w;
      w = 0;
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= '0;
      if (e[1] && e[3] && wk[2]) {wk[6], st[0], w} = 3'h7;
      if (e[1] && e[2] && wk[1]) {wk[5], st[1], w} = 3'h7;
      if (e[1] && !e[0] && wk[9]) {st[2], w} = 2'h3;
      @(negedge clk);
      check("wake_request", wrq, w);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // The ceiling sits well above the roughly 900 cycles the tests need.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         complete_run();
      end
   end

   initial
   begin
      void'($urandom(77));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      outs();
      for (int a = 0; a < 16; a++) rd(4'(a));
      $display("reset values test done");
      // Neither data path runs in this bench, so any checksum write is
      // legal and pad stripping is never on beside the receive engine.
      for (int i = 0; i < 40; i++)
      begin
         wr(4'($urandom), $urandom);
         rd(4'($urandom));
         outs();
      end
      $display("random access test done");
      wr(IDX_WAKE, 32'h80000000);
      for (int i = 0; i < 9; i++) wr(IDX_FILTER, $urandom);
      for (int i = 0; i < 11; i++) rd(IDX_FILTER);
      wr(IDX_WAKE, 32'h80000000);
      outs();
      rd(IDX_FILTER);
      $display("filter pointer test done");
      wr(IDX_CSUM, 32'hFFFFFFFF);
      outs();
      rd(IDX_CSUM);
      wr(IDX_CSUM, 32'h00000002);
      outs();
      rd(IDX_CSUM);
      $display("checksum test done");
      for (int i = 0; i < 60; i++)
      begin
         wr(IDX_WAKE, $urandom & 32'h206);
         if (i % 3 == 0) wr(IDX_IRQ_MASK, $urandom);
         evt(4'($urandom));
         outs();
         if (i % 4 == 0) wr(IDX_IRQ_STATUS, $urandom);
         rd(IDX_WAKE);
         rd(IDX_IRQ_STATUS);
      end
      $display("event test done");
      complete_run();
   end
endmodule
